// >>> design/adp_pkg.sv
// record-side digital path control: shared constants and carrier types
// assumes a single 40 mhz system clock and an avalon-mm register master
package adp_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_GAIN_LEFT   = 6'h24;
  localparam logic [5:0] IDX_GAIN_RIGHT  = 6'h25;
  localparam logic [5:0] IDX_FILTER_POL  = 6'h26;
  localparam logic [5:0] IDX_MIC_SELECT  = 6'h27;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_UPDATE     = 8;
  localparam int BIT_HPF_EN     = 4;
  localparam int BIT_CUT_LO     = 5;
  localparam int BIT_INV_LEFT   = 1;
  localparam int BIT_INV_RIGHT  = 0;
  localparam int BIT_MIC_EN     = 12;
  localparam int BIT_MIC_SRC    = 11;
  localparam logic [7:0] GAIN_RESET    = 8'hc0;
  localparam logic [7:0] GAIN_MUTE     = 8'h00;
  localparam logic [7:0] GAIN_TOP      = 8'hef;
  localparam logic       HPF_EN_RESET  = 1'h1;
  localparam logic [1:0] CUT_RESET     = 2'h0;

  // ----------------------------------------------------------------------
  // datapath constants
  // ----------------------------------------------------------------------
  localparam int SAMPLE_W        = 16;
  localparam int LP_FRAC         = 12;
  localparam int LP_W            = SAMPLE_W + LP_FRAC;
  localparam logic [4:0] GAIN_SHIFT_BASE = 5'h1b;
  localparam logic [3:0] HPF_K_HIFI   = 4'hb;
  localparam logic [3:0] HPF_K_VOICE1 = 4'h4;
  localparam logic [3:0] HPF_K_VOICE2 = 4'h3;
  localparam logic [3:0] HPF_K_VOICE3 = 4'h2;

  // ----------------------------------------------------------------------
  // microphone link timing
  // ----------------------------------------------------------------------
  localparam int    SYS_CLK_HZ      = 40_000_000;
  localparam int    MIC_CLK_HZ      = 5_000_000;
  localparam int    MIC_HALF_CYC    = SYS_CLK_HZ / (2 * MIC_CLK_HZ);
  localparam int    MIC_DIV_W       = 4;
  localparam int    MIC_DEC_W       = 6;
  localparam logic [6:0] MIC_ONES_MID = 7'h20;
  localparam int    MIC_SCALE_SH    = 9;
  localparam int    FIFO_DEPTH      = 16;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic signed [SAMPLE_W-1:0] left;
    logic signed [SAMPLE_W-1:0] right;
  } adp_frame_t;

  typedef struct packed {
    logic       hpf_en;
    logic [1:0] cut;
    logic       inv_l;
    logic       inv_r;
    logic       mic_en;
    logic       mic_src;
  } adp_cfg_t;

endpackage

// >>> design/adp_top.sv
// record-side path: register bank, source select, filter, gain, fifo
// assumes avalon-mm master on clk_sys and mic data pins from outside
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// fifo
// --------------------------------------------------------------------------
module adp_fifo #(
  parameter int W = 32,
  parameter int D = adp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  generate
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least two");
    end
  endgenerate

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } adp_fifo_st_t;

  adp_fifo_st_t   st_q;
  adp_fifo_st_t   st_d;
  logic [W-1:0]   mem [D];
  logic           push;
  logic           pop;

  assign in_ready  = (st_q.wr - st_q.rd) != (AW+1)'(D);
  assign out_valid = st_q.wr != st_q.rd;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[st_q.rd[AW-1:0]];

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + 1'b1;
    end
    if (pop) begin
      st_d.rd = st_q.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
    if (push) begin
      mem[st_q.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

// --------------------------------------------------------------------------
// top
// --------------------------------------------------------------------------
module adp_top #(
  parameter int FIFO_D = adp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // avalon-mm slave
  input  wire logic [7:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  output logic [31:0]        readdata,
  output logic               waitrequest,
  // converter samples
  input  wire logic          adc_valid,
  output logic               adc_ready,
  input  wire adp_pkg::adp_frame_t adc_frame,
  // microphone pins
  output logic               mic_clock_out,
  input  wire logic          mic_data_first,
  input  wire logic          mic_data_second,
  // processed samples
  output logic               rec_valid,
  input  wire logic          rec_ready,
  output adp_pkg::adp_frame_t rec_frame
);
  localparam int SW = adp_pkg::SAMPLE_W;
  localparam int LW = adp_pkg::LP_W;

  generate
    if (adp_pkg::MIC_HALF_CYC < 1 ||
        adp_pkg::MIC_HALF_CYC >= (1 << adp_pkg::MIC_DIV_W)) begin : g_bad
      $error("mic clock divider does not fit its counter");
    end
  endgenerate

  typedef struct packed {
    logic                            ack;
    logic [15:0]                     rdata;
    logic [7:0]                      stg_l;
    logic [7:0]                      stg_r;
    logic [7:0]                      gain_l;
    logic [7:0]                      gain_r;
    adp_pkg::adp_cfg_t               cfg;
    logic [adp_pkg::MIC_DIV_W-1:0]   div;
    logic                            mclk;
    logic [1:0]                      sync1;
    logic [1:0]                      sync2;
    logic [adp_pkg::MIC_DEC_W-1:0]   per;
    logic [6:0]                      ones_l;
    logic [6:0]                      ones_r;
    logic                            mic_v;
    adp_pkg::adp_frame_t             mic_f;
    logic signed [LW-1:0]            lp_l;
    logic signed [LW-1:0]            lp_r;
    logic                            pv;
    adp_pkg::adp_frame_t             pf;
  } adp_st_t;

  adp_st_t               st_q;
  adp_st_t               st_d;
  logic                  req;
  logic                  fifo_ready;
  logic                  take;
  logic                  src_v;
  adp_pkg::adp_frame_t   src_f;
  adp_pkg::adp_frame_t   proc_f;
  logic signed [LW-1:0]  lp_l_n;
  logic signed [LW-1:0]  lp_r_n;
  logic                  mic_bit;

  // ------------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------------
  function automatic logic signed [SW-1:0] sat(
    input logic signed [33:0] v);
    if (v > 34'sh0_0000_7fff) begin
      return 16'sh7fff;
    end else if (v < -34'sh0_0000_8000) begin
      return -16'sh8000;
    end
    return v[SW-1:0];
  endfunction

  // 2^(i/16) in q2.15, one octave of 16 steps of 0.375dB
  function automatic logic [16:0] mant(input logic [3:0] i);
    unique case (i)
      4'h0: return 17'h08000; 4'h1: return 17'h085ab;
      4'h2: return 17'h08b96; 4'h3: return 17'h091c4;
      4'h4: return 17'h09838; 4'h5: return 17'h09ef5;
      4'h6: return 17'h0a5ff; 4'h7: return 17'h0ad58;
      4'h8: return 17'h0b505; 4'h9: return 17'h0bd09;
      4'ha: return 17'h0c567; 4'hb: return 17'h0ce25;
      4'hc: return 17'h0d745; 4'hd: return 17'h0e0cd;
      4'he: return 17'h0eac1; 4'hf: return 17'h0f525;
    endcase
  endfunction

  function automatic logic signed [SW-1:0] gain(
    input logic signed [SW-1:0] x, input logic [7:0] code);
    logic [7:0]          c;
    logic signed [33:0]  p;
    logic [4:0]          sh;
    c = (code > adp_pkg::GAIN_TOP) ? adp_pkg::GAIN_TOP : code;
    if (c == adp_pkg::GAIN_MUTE) begin
      return '0;
    end
    p  = 34'(x * $signed({1'b0, mant(c[3:0])}));
    sh = adp_pkg::GAIN_SHIFT_BASE - {1'b0, c[7:4]};
    return sat(p >>> sh);
  endfunction

  function automatic logic signed [SW-1:0] neg(
    input logic signed [SW-1:0] x, input logic inv);
    if (!inv) begin
      return x;
    end
    return sat(-34'(x));
  endfunction

  function automatic logic [3:0] hpf_k(input logic [1:0] cut);
    unique case (cut)
      2'h0: return adp_pkg::HPF_K_HIFI;
      2'h1: return adp_pkg::HPF_K_VOICE1;
      2'h2: return adp_pkg::HPF_K_VOICE2;
      2'h3: return adp_pkg::HPF_K_VOICE3;
    endcase
  endfunction

  // one-pole tracker; advances once per sample so corner scales with fs
  function automatic logic signed [LW-1:0] lp_next(
    input logic signed [SW-1:0] x, input logic signed [LW-1:0] lp,
    input logic [3:0] k);
    logic signed [LW:0] e;
    e = {x[SW-1], x, {adp_pkg::LP_FRAC{1'b0}}} - {lp[LW-1], lp};
    return LW'(lp + LW'(e >>> k));
  endfunction

  function automatic logic signed [SW-1:0] hp(
    input logic signed [SW-1:0] x, input logic signed [LW-1:0] lp,
    input logic en);
    if (!en) begin
      return x;
    end
    return sat(34'(x) - 34'($signed(lp[LW-1:adp_pkg::LP_FRAC])));
  endfunction

  // ------------------------------------------------------------------------
  // source select and processing
  // ------------------------------------------------------------------------
  assign req       = read || write;
  assign src_v     = st_q.cfg.mic_en ? st_q.mic_v : adc_valid;
  assign src_f     = st_q.cfg.mic_en ? st_q.mic_f : adc_frame;
  assign take      = src_v && (!st_q.pv || fifo_ready);
  assign adc_ready = !st_q.cfg.mic_en && (!st_q.pv || fifo_ready);
  assign mic_bit   = st_q.cfg.mic_src ? st_q.sync2[1] : st_q.sync2[0];

  assign lp_l_n = lp_next(src_f.left,  st_q.lp_l, hpf_k(st_q.cfg.cut));
  assign lp_r_n = lp_next(src_f.right, st_q.lp_r, hpf_k(st_q.cfg.cut));

  always_comb begin
    proc_f.left  = neg(gain(hp(src_f.left, st_q.lp_l, st_q.cfg.hpf_en),
                            st_q.gain_l), st_q.cfg.inv_l);
    proc_f.right = neg(gain(hp(src_f.right, st_q.lp_r, st_q.cfg.hpf_en),
                            st_q.gain_r), st_q.cfg.inv_r);
  end

  // ------------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // bus: one wait cycle, then answer
    st_d.ack = req && !st_q.ack;
    if (req && !st_q.ack) begin
      unique case (address[7:2])
        adp_pkg::IDX_GAIN_LEFT:  st_d.rdata = {8'h00, st_q.stg_l};
        adp_pkg::IDX_GAIN_RIGHT: st_d.rdata = {8'h00, st_q.stg_r};
        adp_pkg::IDX_FILTER_POL: begin
          st_d.rdata = '0;
          st_d.rdata[adp_pkg::BIT_CUT_LO +: 2] = st_q.cfg.cut;
          st_d.rdata[adp_pkg::BIT_HPF_EN]      = st_q.cfg.hpf_en;
          st_d.rdata[adp_pkg::BIT_INV_LEFT]    = st_q.cfg.inv_l;
          st_d.rdata[adp_pkg::BIT_INV_RIGHT]   = st_q.cfg.inv_r;
        end
        adp_pkg::IDX_MIC_SELECT: begin
          st_d.rdata = '0;
          st_d.rdata[adp_pkg::BIT_MIC_EN]  = st_q.cfg.mic_en;
          st_d.rdata[adp_pkg::BIT_MIC_SRC] = st_q.cfg.mic_src;
        end
        default: st_d.rdata = '0;
      endcase
    end
    if (write && st_q.ack) begin
      unique case (address[7:2])
        adp_pkg::IDX_GAIN_LEFT, adp_pkg::IDX_GAIN_RIGHT: begin
          if (address[7:2] == adp_pkg::IDX_GAIN_LEFT) begin
            st_d.stg_l = writedata[7:0];
          end else begin
            st_d.stg_r = writedata[7:0];
          end
          if (writedata[adp_pkg::BIT_UPDATE]) begin
            st_d.gain_l = st_d.stg_l;
            st_d.gain_r = st_d.stg_r;
          end
        end
        adp_pkg::IDX_FILTER_POL: begin
          st_d.cfg.cut    = writedata[adp_pkg::BIT_CUT_LO +: 2];
          st_d.cfg.hpf_en = writedata[adp_pkg::BIT_HPF_EN];
          st_d.cfg.inv_l  = writedata[adp_pkg::BIT_INV_LEFT];
          st_d.cfg.inv_r  = writedata[adp_pkg::BIT_INV_RIGHT];
        end
        adp_pkg::IDX_MIC_SELECT: begin
          st_d.cfg.mic_en  = writedata[adp_pkg::BIT_MIC_EN];
          st_d.cfg.mic_src = writedata[adp_pkg::BIT_MIC_SRC];
        end
        default: ;
      endcase
    end

    // microphone pins through two flops
    st_d.sync1 = {mic_data_second, mic_data_first};
    st_d.sync2 = st_q.sync1;

    // microphone clock and one-bit decimation
    st_d.mic_v = st_q.mic_v && !take;
    if (!st_q.cfg.mic_en) begin
      st_d.div    = '0;
      st_d.mclk   = 1'b0;
      st_d.mic_v  = 1'b0;
      st_d.per    = '0;
      st_d.ones_l = '0;
      st_d.ones_r = '0;
    end else if (st_q.div ==
                 adp_pkg::MIC_DIV_W'(adp_pkg::MIC_HALF_CYC - 1)) begin
      st_d.div  = '0;
      st_d.mclk = !st_q.mclk;
      if (!st_q.mclk) begin
        // falling half ends: left bit is settled
        st_d.ones_l = st_q.ones_l + {6'h00, mic_bit};
      end else begin
        st_d.ones_r = st_q.ones_r + {6'h00, mic_bit};
        st_d.per    = st_q.per + 1'b1;
        if (&st_q.per) begin
          st_d.mic_v       = 1'b1;
          st_d.mic_f.left  = SW'($signed(
            {st_d.ones_l - adp_pkg::MIC_ONES_MID}) <<< adp_pkg::MIC_SCALE_SH);
          st_d.mic_f.right = SW'($signed(
            {st_d.ones_r - adp_pkg::MIC_ONES_MID}) <<< adp_pkg::MIC_SCALE_SH);
          st_d.ones_l      = '0;
          st_d.ones_r      = '0;
        end
      end
    end else begin
      st_d.div = st_q.div + 1'b1;
    end

    // one-stage pipe in front of the fifo
    if (fifo_ready) begin
      st_d.pv = 1'b0;
    end
    if (take) begin
      st_d.pv   = 1'b1;
      st_d.pf   = proc_f;
      st_d.lp_l = lp_l_n;
      st_d.lp_r = lp_r_n;
    end
  end

  // ------------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q            <= '0;
      st_q.stg_l      <= adp_pkg::GAIN_RESET;
      st_q.stg_r      <= adp_pkg::GAIN_RESET;
      st_q.gain_l     <= adp_pkg::GAIN_RESET;
      st_q.gain_r     <= adp_pkg::GAIN_RESET;
      st_q.cfg.hpf_en <= adp_pkg::HPF_EN_RESET;
      st_q.cfg.cut    <= adp_pkg::CUT_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------------
  // outputs and fifo
  // ------------------------------------------------------------------------
  assign waitrequest   = req && !st_q.ack;
  assign readdata      = {16'h0000, st_q.rdata};
  assign mic_clock_out = st_q.mclk;

  adp_fifo #(
    .W (2 * SW),
    .D (FIFO_D)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (st_q.pv),
    .in_ready  (fifo_ready),
    .in_data   (st_q.pf),
    .out_valid (rec_valid),
    .out_ready (rec_ready),
    .out_data  (rec_frame)
  );
endmodule

// >>> bench/adp_top_monitor.sv
// checker for the record path: bus wait, mic clock, stream relations
// assumes it is bound onto adp_top and sees only its ports
`timescale 1ns/1ps
module adp_top_monitor #(
  parameter int FIFO_D = 16
) (
  // clock and reset
  input wire logic                clk_sys,
  input wire logic                rst,
  // register bus
  input wire logic [7:0]          address,
  input wire logic                read,
  input wire logic                write,
  input wire logic [31:0]         writedata,
  input wire logic [31:0]         readdata,
  input wire logic                waitrequest,
  // converter side
  input wire logic                adc_valid,
  input wire logic                adc_ready,
  input wire adp_pkg::adp_frame_t adc_frame,
  // microphone pins
  input wire logic                mic_clock_out,
  input wire logic                mic_data_first,
  input wire logic                mic_data_second,
  // output side
  input wire logic                rec_valid,
  input wire logic                rec_ready,
  input wire adp_pkg::adp_frame_t rec_frame
);
  // ----------------------------------------------------------------------
  // shadow of the mic mode bit
  // ----------------------------------------------------------------------
  logic       mic_q;
  logic [1:0] age_q;
  logic [5:0] idx;
  logic       acc_r;
  logic       wr_mic;
  assign idx    = address[7:2];
  assign acc_r  = read && !waitrequest;
  assign wr_mic = write && !waitrequest && idx == 6'h27;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mic_q <= 1'b0;
      age_q <= 2'h0;
    end else if (wr_mic && writedata[12] != mic_q) begin
      mic_q <= writedata[12];
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ack;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence s_mclk_high;
    (mic_clock_out || !mic_q) [*4] ##1 (!mic_clock_out || !mic_q);
  endsequence
  AST_REQ_WAIT: assert property ((read || write) && !$past(read || write)
    |-> s_ack) else $error("bus request not answered after one wait");
  AST_RD_HIGH0: assert property (acc_r && idx == 6'h27
    |-> readdata[12] == mic_q && readdata[31:16] == 16'h0)
    else $error("mic select reads back wrong");
  AST_UPD_RD0: assert property ((idx == 6'h24 || idx == 6'h25) && acc_r
    |-> !readdata[8]) else $error("update bit reads back set");
  AST_MCLK_LOW: assert property (!mic_q && age_q == 2'h3
    |-> !mic_clock_out) else $error("mic clock runs while mic mode off");
  AST_MCLK_RATE: assert property (mic_q && age_q == 2'h3
    && $rose(mic_clock_out) |-> s_mclk_high) else $error("mic clock period");
  AST_ADC_HOLD: assert property (mic_q && age_q == 2'h3
    |-> !adc_ready) else $error("converter taken in mic mode");
  AST_ADC_TAKE: assert property (!mic_q && age_q == 2'h3
    && !rec_valid |-> adc_ready) else $error("converter refused when idle");
  AST_REC_HOLD: assert property (rec_valid && !rec_ready
    |=> rec_valid && $stable(rec_frame)) else $error("output frame moved");
  AST_PASS_LAT: assert property (adc_valid && adc_ready
    |-> ##[1:3] rec_valid) else $error("taken frame not delivered");
endmodule

bind adp_top adp_top_monitor #(.FIFO_D(FIFO_D)) mon (
  .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .adc_valid(adc_valid),
  .adc_ready(adc_ready), .adc_frame(adc_frame),
  .mic_clock_out(mic_clock_out), .mic_data_first(mic_data_first),
  .mic_data_second(mic_data_second), .rec_valid(rec_valid),
  .rec_ready(rec_ready), .rec_frame(rec_frame));

// >>> bench/adp_mic_model.sv
// two digital microphones: first pin all ones, second pin all zeros
// assumes mic_clock_out from the design; lines wander when clock stops
`timescale 1ns/1ps
module adp_mic_model (
  // clocks
  input wire logic clk_sys,
  input wire logic mic_clock_out,
  // data pins
  output logic     mic_data_first,
  output logic     mic_data_second
);
  logic       last_q;
  logic [3:0] idle_q;
  initial begin
    last_q          = 1'b0;
    idle_q          = 4'hf;
    mic_data_first  = 1'b0;
    mic_data_second = 1'b1;
  end
  always @(posedge clk_sys) begin
    last_q <= mic_clock_out;
    if (mic_clock_out != last_q)
      idle_q <= 4'h0;
    else if (idle_q != 4'hf)
      idle_q <= idle_q + 4'h1;
    if (idle_q > 4'h8) begin
      mic_data_first  <= ~mic_data_first;
      mic_data_second <= ~mic_data_second;
    end else begin
      mic_data_first  <= 1'b1;
      mic_data_second <= 1'b0;
    end
  end
endmodule

// >>> bench/test_adc_digital_path_control.sv
// self-checking bench for the record path control block
// assumes adp_top, adp_fifo and the mic model are compiled alongside
`timescale 1ns/1ps
module test_adc_digital_path_control;
  logic                clk_sys, rst, read, write, waitrequest;
  logic                adc_valid, adc_ready, rec_valid, rec_ready, ok;
  logic                mic_clock_out, mic_data_first, mic_data_second;
  logic [7:0]          address;
  logic [31:0]         writedata, readdata, rd;
  adp_pkg::adp_frame_t adc_frame, rec_frame, got;
  int                  num_errors, num_checks, n, k;
  adp_top #(.FIFO_D(16)) DUT (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .adc_frame(adc_frame),
    .mic_clock_out(mic_clock_out), .mic_data_first(mic_data_first),
    .mic_data_second(mic_data_second), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .rec_frame(rec_frame));
  adp_mic_model mic (.clk_sys(clk_sys), .mic_clock_out(mic_clock_out),
    .mic_data_first(mic_data_first), .mic_data_second(mic_data_second));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic hang;
    num_errors++;
    give_verdict;
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cmp_frame(input adp_pkg::adp_frame_t g, e);
    cmp_reg(g, e);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (waitrequest !== 1'b0 && i < 50);
    if (waitrequest !== 1'b0) hang;
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp_reg(rd, e);
  endtask
  task automatic push(input logic [31:0] f, input int lim);
    int i;
    @(posedge clk_sys);
    adc_valid <= 1'b1;
    adc_frame <= f;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (adc_ready !== 1'b1 && i < lim);
    ok = (adc_ready === 1'b1);
    adc_valid <= 1'b0;
  endtask
  task automatic pull;
    int i;
    @(posedge clk_sys);
    rec_ready <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (rec_valid !== 1'b1 && i < 2000);
    if (rec_valid !== 1'b1) hang;
    got = rec_frame;
    rec_ready <= 1'b0;
  endtask
  task automatic xfer(input logic [31:0] f, input logic [31:0] e);
    push(f, 50);
    if (!ok) hang;
    pull;
    cmp_frame(got, e);
  endtask
  task automatic flush;
    @(posedge clk_sys);
    rec_ready <= 1'b1;
    repeat (600) @(posedge clk_sys);
    rec_ready <= 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk_sys);
    hang;
  end
  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    adc_valid = 1'b0;
    adc_frame = 32'h0;
    rec_ready = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(8'h90, 32'h00c0);
    rd_chk(8'h94, 32'h00c0);
    rd_chk(8'h98, 32'h0010);
    rd_chk(8'h9c, 32'h0000);
    wr(8'h40, 32'hffff);
    rd_chk(8'h40, 32'h0000);
    for (n = 0; n < 4; n++) begin
      wr(8'h98, 32'(n << 5));
      rd_chk(8'h98, 32'(n << 5));
    end
    xfer(32'h03e8f830, 32'h03e8f830);
    wr(8'h90, 32'h0000);
    rd_chk(8'h90, 32'h0000);
    xfer(32'h03e8f830, 32'h03e8f830);
    wr(8'h94, 32'h01c0);
    xfer(32'h03e8f830, 32'h0000f830);
    wr(8'h90, 32'h00ef);
    wr(8'h94, 32'h01ff);
    push(32'h00640064, 50);
    if (!ok) hang;
    pull;
    cmp_reg({16'h0, got.left}, {16'h0, got.right});
    cmp_reg(32'(got.left > 16'sd750 && got.left < 16'sd770),
            32'h1);
    wr(8'h94, 32'h00c0);
    wr(8'h90, 32'h01c0);
    wr(8'h98, 32'h0002);
    xfer(32'h800004d2, 32'h7fff04d2);
    wr(8'h98, 32'h0001);
    xfer(32'h0005fff9, 32'h00050007);
    wr(8'h98, 32'h0070);
    for (n = 0; n < 16; n++) begin
      push(32'h1f401f40, 50);
      pull;
    end
    cmp_reg(32'(got.left < 16'sh03e8), 32'h1);
    wr(8'h98, 32'h0000);
    for (n = 0; n < 24; n++) begin
      push(32'(n), 8);
      if (!ok) break;
    end
    cmp_reg(32'(n >= 16), 32'h1);
    for (k = 0; k < n; k++) begin
      pull;
      cmp_frame(got, 32'(k));
    end
    wr(8'h9c, 32'h1000);
    flush;
    pull;
    cmp_frame(got, 32'h40004000);
    wr(8'h9c, 32'h1800);
    flush;
    pull;
    cmp_frame(got, 32'hc000c000);
    wr(8'h9c, 32'h0000);
    repeat (10) @(posedge clk_sys);
    cmp_reg({31'h0, mic_clock_out}, 32'h0);
    give_verdict;
  end
endmodule
